//--- hw/ctwd_defines.svh
// Purpose: Constants for the transfer/wait decoder
// Assumes: 8-bit core, 16-bit address space
// Notes:   Offsets, fields and counts live here; types live in the package
`ifndef CTWD_DEFINES_SVH
`define CTWD_DEFINES_SVH
// Opcodes handled here
`define CTWD_OP_XFER_XA    8'h9f
`define CTWD_OP_XFER_XSP   8'h94
`define CTWD_OP_WAIT       8'h8f
// Cycle counts per opcode
`define CTWD_CYC_XFER_XA   2'd1
`define CTWD_CYC_XFER_XSP  2'd2
`define CTWD_CYC_WAIT      2'd2
// Address-mode helpers
`define CTWD_DIRECT_HIGH   8'h00
`define CTWD_VECTOR_PAGE   8'hff
`define CTWD_BITNUM_MAX    3'h7
// Reset values
`define CTWD_RST_WORD      16'h0000
`define CTWD_RST_BYTE      8'h00
`endif

//--- hw/ctwd_pkg.sv
// Purpose: Types for the transfer/wait decoder
// Assumes: Constants come from ctwd_defines.svh
// Notes:   Bus cycle kinds and the address-mode selector
package ctwd_pkg;
  // Kind of activity on each bus clock
  typedef enum logic [2:0] {
    CYC_FREE, CYC_FETCH, CYC_READ, CYC_WRITE,
    CYC_PUSH, CYC_POP, CYC_VECTOR, CYC_IDLE
  } ctwd_cyc_e;
  // Operand address forms
  typedef enum logic [2:0] {
    AM_DIRECT, AM_IX_OFF8, AM_IX_OFF16, AM_IX_POSTINC,
    AM_IX_OFF8_POSTINC, AM_SP_OFF8, AM_SP_OFF16, AM_REL
  } ctwd_mode_e;
  // Bus request toward memory
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    ctwd_cyc_e   kind;
  } ctwd_bus_s;
  // Core register snapshot
  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] index;
    logic [15:0] stack_pointer;
    logic [7:0]  condition_flags;
  } ctwd_regs_s;
endpackage : ctwd_pkg

//--- hw/ctwd_decode.sv
// Purpose: Decode and sequence transfer and wait opcodes, form addresses
// Assumes: Opcode arrives with a valid strobe, one instruction at a time
// Notes:   One clock, async reset; every piece of logic lives here
`timescale 1ns/1ns
`include "ctwd_defines.svh"
module ctwd_decode (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Instruction issue
  input  wire logic                op_valid,
  input  wire logic [7:0]          op_code,
  output logic                     op_ready,
  // Address-mode request
  input  wire ctwd_pkg::ctwd_mode_e am_mode,
  input  wire logic [15:0]         am_operand,
  input  wire logic [15:0]         am_pc_next,
  input  wire logic [2:0]          am_bitnum,
  output logic [15:0]              am_addr,
  output logic [7:0]               am_bitmask,
  // Stack, vector and operand traffic
  input  wire logic                push_req,
  input  wire logic                pop_req,
  input  wire logic                vec_req,
  input  wire logic [7:0]          vec_slot,
  input  wire logic                rd_req,
  input  wire logic                wr_req,
  input  wire logic [7:0]          wr_data,
  // Wake sources
  input  wire logic                irq,
  // Core state and bus
  input  wire ctwd_pkg::ctwd_regs_s regs_in,
  input  wire logic                regs_load,
  output ctwd_pkg::ctwd_regs_s     regs,
  output logic                     int_mask,
  output logic                     halted,
  output ctwd_pkg::ctwd_bus_s      bus
);
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_FREE, S_FETCH, S_HALT, S_VEC_LO
  } ctwd_st_e;

  ctwd_st_e             st_r;      // Current state
  logic [7:0]           op_r;      // Opcode held through its cycles
  logic [15:0]          pc_r;      // Next program location
  ctwd_pkg::ctwd_bus_s  bus_r;     // Registered bus request
  ctwd_pkg::ctwd_regs_s regs_r;    // Architectural registers
  logic                 mask_r;    // Interrupt mask
  logic [15:0]          am_r;      // Registered effective address
  logic [7:0]           vslot_r;   // Vector slot for low byte

  // Sign extension of a branch byte, used for relative targets
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction : sext8

  // Build one bus request
  function automatic ctwd_pkg::ctwd_bus_s mk(
    input logic [15:0] a, input logic [7:0] d,
    input logic r, input logic w, input ctwd_pkg::ctwd_cyc_e k);
    mk.addr  = a;
    mk.wdata = d;
    mk.rd    = r;
    mk.wr    = w;
    mk.kind  = k;
  endfunction : mk

  // New work is accepted only while idle; a halt blocks bus and register requests except a register load, while address formation goes on
  assign op_ready = (st_r == S_IDLE);
  assign regs     = regs_r;
  assign int_mask = mask_r;
  assign halted   = (st_r == S_HALT);
  assign bus      = bus_r;
  assign am_addr  = am_r;
  // Bit selection decoded from a three-bit number
  assign am_bitmask = 8'h01 << am_bitnum;

  // Effective address formation, registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      am_r <= `CTWD_RST_WORD;
    end else begin
      case (am_mode)
        // Direct page only reaches the first 256 bytes
        ctwd_pkg::AM_DIRECT:
          am_r <= {`CTWD_DIRECT_HIGH, am_operand[7:0]};
        // Offset is zero-extended, never sign-extended
        ctwd_pkg::AM_IX_OFF8:
          am_r <= regs_r.index + {8'h00, am_operand[7:0]};
        ctwd_pkg::AM_IX_OFF16:
          am_r <= regs_r.index + am_operand;
        // Post-increment forms address through the unmodified index
        ctwd_pkg::AM_IX_POSTINC:
          am_r <= regs_r.index;
        ctwd_pkg::AM_IX_OFF8_POSTINC:
          am_r <= regs_r.index + {8'h00, am_operand[7:0]};
        ctwd_pkg::AM_SP_OFF8:
          am_r <= regs_r.stack_pointer + {8'h00, am_operand[7:0]};
        ctwd_pkg::AM_SP_OFF16:
          am_r <= regs_r.stack_pointer + am_operand;
        // A signed byte bounds the reach to -128..+127
        ctwd_pkg::AM_REL:
          am_r <= am_pc_next + sext8(am_operand[7:0]);
        default:
          am_r <= `CTWD_RST_WORD;
      endcase
    end
  end

  // Sequencer and bus cycle generation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= S_IDLE;
      op_r    <= `CTWD_RST_BYTE;
      pc_r    <= `CTWD_RST_WORD;
      bus_r   <= mk(`CTWD_RST_WORD, `CTWD_RST_BYTE, 1'b0, 1'b0,
                    ctwd_pkg::CYC_IDLE);
      vslot_r <= `CTWD_RST_BYTE;
    end else begin
      bus_r <= mk(`CTWD_RST_WORD, `CTWD_RST_BYTE, 1'b0, 1'b0,
                  ctwd_pkg::CYC_IDLE);
      case (st_r)
        S_IDLE: begin
          if (op_valid && op_code == `CTWD_OP_XFER_XA) begin
            // Single fetch of the next opcode
            bus_r <= mk(pc_r, `CTWD_RST_BYTE, 1'b1, 1'b0,
                        ctwd_pkg::CYC_FETCH);
            pc_r  <= pc_r + 16'h0001;
          end else if (op_valid && (op_code == `CTWD_OP_XFER_XSP ||
                                    op_code == `CTWD_OP_WAIT)) begin
            // Free cycle is a read with no data use
            op_r  <= op_code;
            st_r  <= S_FETCH;
            bus_r <= mk(pc_r, `CTWD_RST_BYTE, 1'b1, 1'b0,
                        ctwd_pkg::CYC_FREE);
          end else if (vec_req) begin
            // High byte first from the top page
            vslot_r <= vec_slot;
            st_r    <= S_VEC_LO;
            bus_r   <= mk({`CTWD_VECTOR_PAGE, vec_slot}, `CTWD_RST_BYTE,
                          1'b1, 1'b0, ctwd_pkg::CYC_VECTOR);
          end else if (push_req) begin
            bus_r <= mk(regs_r.stack_pointer, wr_data, 1'b0, 1'b1,
                        ctwd_pkg::CYC_PUSH);
          end else if (pop_req) begin
            bus_r <= mk(regs_r.stack_pointer + 16'h0001, `CTWD_RST_BYTE,
                        1'b1, 1'b0, ctwd_pkg::CYC_POP);
          end else if (wr_req) begin
            bus_r <= mk(am_r, wr_data, 1'b0, 1'b1,
                        ctwd_pkg::CYC_WRITE);
          end else if (rd_req) begin
            bus_r <= mk(am_r, `CTWD_RST_BYTE, 1'b1, 1'b0,
                        ctwd_pkg::CYC_READ);
          end
        end
        S_FETCH: begin
          // Second cycle fetches the next opcode
          bus_r <= mk(pc_r, `CTWD_RST_BYTE, 1'b1, 1'b0,
                      ctwd_pkg::CYC_FETCH);
          pc_r  <= pc_r + 16'h0001;
          st_r  <= (op_r == `CTWD_OP_WAIT) ? S_HALT : S_IDLE;
        end
        S_HALT: begin
          // Bus stays idle; only an interrupt wakes the core
          if (irq) begin
            st_r <= S_IDLE;
          end
        end
        S_VEC_LO: begin
          bus_r <= mk({`CTWD_VECTOR_PAGE, vslot_r + 8'h01}, `CTWD_RST_BYTE,
                      1'b1, 1'b0, ctwd_pkg::CYC_VECTOR);
          st_r  <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Register updates; flags are never touched by the transfers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regs_r <= '0;
    end else if (regs_load) begin
      regs_r <= regs_in;
    end else if (st_r == S_IDLE && op_valid &&
                 (op_code == `CTWD_OP_XFER_XA ||
                  op_code == `CTWD_OP_XFER_XSP ||
                  op_code == `CTWD_OP_WAIT)) begin
      // Unknown opcodes fall through, matching the bus priority
      if (op_code == `CTWD_OP_XFER_XA) begin
        regs_r.acc <= regs_r.index[7:0];
      end else if (op_code == `CTWD_OP_XFER_XSP) begin
        regs_r.stack_pointer <= regs_r.index - 16'h0001;
      end
    end else if (st_r == S_IDLE && (push_req && !vec_req)) begin
      regs_r.stack_pointer <= regs_r.stack_pointer - 16'h0001;
    end else if (st_r == S_IDLE && pop_req && !vec_req) begin
      regs_r.stack_pointer <= regs_r.stack_pointer + 16'h0001;
    end else if (st_r == S_IDLE && (rd_req || wr_req) && !vec_req &&
                 (am_mode == ctwd_pkg::AM_IX_POSTINC ||
                  am_mode == ctwd_pkg::AM_IX_OFF8_POSTINC)) begin
      regs_r.index <= regs_r.index + 16'h0001;
    end
  end

  // Interrupt mask: cleared by the wait opcode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_r <= 1'b1;
    end else if (st_r == S_IDLE && op_valid &&
                 op_code == `CTWD_OP_WAIT) begin
      mask_r <= 1'b0;
    end
  end

  // Checks
  a_xa_copy_flags: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == S_IDLE && op_valid && !regs_load &&
     op_code == `CTWD_OP_XFER_XA) |=>
    (regs_r.acc == $past(regs_r.index[7:0]) &&
     regs_r.condition_flags == $past(regs_r.condition_flags) &&
     bus_r.kind == ctwd_pkg::CYC_FETCH))
    else $error("index low copy wrong");
  a_xsp_load: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == S_IDLE && op_valid && !regs_load &&
     op_code == `CTWD_OP_XFER_XSP) |=>
    (regs_r.stack_pointer == $past(regs_r.index) - 16'h0001 &&
     bus_r.kind == ctwd_pkg::CYC_FREE) ##1
    (bus_r.kind == ctwd_pkg::CYC_FETCH))
    else $error("stack load sequence wrong");
  a_wait_halt: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == S_IDLE && op_valid && op_code == `CTWD_OP_WAIT) |=>
    !mask_r ##1 (bus_r.kind == ctwd_pkg::CYC_FETCH && halted))
    else $error("wait sequence wrong");
  a_direct_page: assert property (@(posedge clk) disable iff (!resetn)
    (am_mode == ctwd_pkg::AM_DIRECT) |=> (am_r[15:8] == 8'h00))
    else $error("direct page high byte set");
  a_free_is_read: assert property (@(posedge clk) disable iff (!resetn)
    (bus_r.kind == ctwd_pkg::CYC_FREE) |-> (bus_r.rd && !bus_r.wr) ##1
    (bus_r.kind != ctwd_pkg::CYC_FREE))
    else $error("free cycle not a single read");
  a_halt_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (halted && $past(halted)) |-> (!bus_r.rd && !bus_r.wr))
    else $error("bus active while halted");
  a_vector_order: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == S_IDLE && vec_req && !op_valid) |=>
    (bus_r.addr[15:8] == 8'hff) ##1
    (bus_r.kind == ctwd_pkg::CYC_VECTOR &&
     bus_r.addr == $past(bus_r.addr) + 16'h0001))
    else $error("vector order wrong");
  a_push_writes: assert property (@(posedge clk) disable iff (!resetn)
    (bus_r.kind == ctwd_pkg::CYC_PUSH) |-> (bus_r.wr && !bus_r.rd))
    else $error("push not a write");
  // A pop is always a single read
  a_pop_reads: assert property (@(posedge clk) disable iff (!resetn)
    (bus_r.kind == ctwd_pkg::CYC_POP) |-> (bus_r.rd && !bus_r.wr))
    else $error("pop not a read");
  // Exactly one bit of the byte is selected
  a_bit_onehot: assert property (@(posedge clk) disable iff (!resetn)
    $onehot(am_bitmask) && am_bitmask[am_bitnum])
    else $error("bit selector not one-hot");
  // Index steps by one after a post-increment access
  a_postinc_step: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == S_IDLE && !regs_load && !op_valid && !vec_req &&
     !push_req && !pop_req && (rd_req || wr_req) &&
     (am_mode == ctwd_pkg::AM_IX_POSTINC ||
      am_mode == ctwd_pkg::AM_IX_OFF8_POSTINC)) |=>
    (regs_r.index == $past(regs_r.index) + 16'h0001))
    else $error("post-increment missing");
  // Fetch reads the location just before the advanced counter
  a_fetch_next: assert property (@(posedge clk) disable iff (!resetn)
    (bus_r.kind == ctwd_pkg::CYC_FETCH) |->
    (bus_r.rd && !bus_r.wr && bus_r.addr == pc_r - 16'h0001))
    else $error("fetch not sequential");
  // Short index offset is zero-extended
  a_off8_unsigned: assert property (@(posedge clk) disable iff (!resetn)
    (am_mode == ctwd_pkg::AM_IX_OFF8) |=>
    (am_r == $past(regs_r.index) + {8'h00, $past(am_operand[7:0])}))
    else $error("short index offset not unsigned");
  // Relative target stays within one signed byte of next pc
  a_rel_reach: assert property (@(posedge clk) disable iff (!resetn)
    (am_mode == ctwd_pkg::AM_REL) |=>
    (am_r == $past(am_pc_next) + {{8{$past(am_operand[7])}},
                                  $past(am_operand[7:0])}))
    else $error("relative target wrong");
  // Long stack offset uses all sixteen bits
  a_sp_off16: assert property (@(posedge clk) disable iff (!resetn)
    (am_mode == ctwd_pkg::AM_SP_OFF16) |=>
    (am_r == $past(regs_r.stack_pointer) + $past(am_operand)))
    else $error("long stack offset wrong");
  // A wake request leaves the halt at the next edge
  a_halt_wake: assert property (@(posedge clk) disable iff (!resetn)
    (halted && irq) |=> !halted)
    else $error("halt not left on wake");
endmodule : ctwd_decode

//--- tb/ctwd_mem_model.sv
// Purpose: Memory behind the system bus of the decoder
// Assumes: Bus request is registered and stands one clock
// Notes:   Only writes are kept; the bus carries no read data back
`timescale 1ns/1ns
module ctwd_mem_model (
  // Clock
  input wire logic                clk,
  // Bus from the decoder
  input wire ctwd_pkg::ctwd_bus_s bus
);
  // Byte store for the whole 16-bit space
  logic [7:0] mem [0:65535];

  // Capture every write strobe at the end of its cycle
  always_ff @(posedge clk) begin
    if (bus.wr) begin
      mem[bus.addr] <= bus.wdata;
    end
  end
endmodule : ctwd_mem_model

//--- tb/cpu_transfer_wait_decode_tb_top.sv
// Purpose: Directed bench for the transfer/wait decoder
// Assumes: Inputs change 1 ns after each rising edge
// Notes:   Bus waits are bounded to 4 cycles
`timescale 1ns/1ns
`define CHK(a,e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module cpu_transfer_wait_decode_tb_top;
  // Clock, reset and stimulus
  logic                 clk = 1'b0;
  logic                 resetn, op_valid, op_ready, push_req, pop_req;
  logic                 vec_req, rd_req, wr_req, irq, regs_load;
  logic                 int_mask, halted;
  logic [7:0]           op_code, vec_slot, wr_data, am_bitmask;
  logic [15:0]          am_operand, am_pc_next, am_addr;
  logic [2:0]           am_bitnum;
  ctwd_pkg::ctwd_mode_e am_mode;
  ctwd_pkg::ctwd_regs_s regs_in, regs;
  ctwd_pkg::ctwd_bus_s  bus;
  // Tallies
  int                   n_mismatch = 0;
  int                   n_compared = 0;

  always #2 clk = ~clk;

  ctwd_decode ctwd_decode_i (.clk(clk), .resetn(resetn),
    .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready),
    .am_mode(am_mode), .am_operand(am_operand), .am_pc_next(am_pc_next),
    .am_bitnum(am_bitnum), .am_addr(am_addr), .am_bitmask(am_bitmask),
    .push_req(push_req), .pop_req(pop_req), .vec_req(vec_req),
    .vec_slot(vec_slot), .rd_req(rd_req), .wr_req(wr_req),
    .wr_data(wr_data), .irq(irq), .regs_in(regs_in),
    .regs_load(regs_load), .regs(regs), .int_mask(int_mask),
    .halted(halted), .bus(bus));
  ctwd_mem_model ctwd_mem_model_i (.clk(clk), .bus(bus));

  // Verdict and end of run
  task results;
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // One clock, then settle
  task step;
    @(posedge clk);
    #1;
  endtask : step

  // Preload every core register
  task load(input [7:0] a, input [15:0] x, input [15:0] s, input [7:0] f);
    regs_in = {a, x, s, f};
    regs_load = 1'b1;
    step;
    regs_load = 1'b0;
    step;
  endtask : load

  // Bounded wait for the first bus cycle
  task wait_bus;
    for (int i = 0; i < 4 && bus.kind === ctwd_pkg::CYC_IDLE; i++) step;
    if (bus.kind === ctwd_pkg::CYC_IDLE) begin
      n_mismatch++;
      results();
    end
  endtask : wait_bus

  // Offer one opcode for one edge
  task issue(input [7:0] op);
    op_code = op;
    op_valid = 1'b1;
    step;
    op_valid = 1'b0;
    wait_bus;
  endtask : issue

  // Copy index low, then index minus one into stack pointer
  task t_xfer;
    load(8'h00, 16'h1234, 16'h00ff, 8'h5a);
    issue(8'h9f);
    `CHK(bus.kind, ctwd_pkg::CYC_FETCH)
    step;
    step;
    `CHK(regs.acc, 8'h34)
    `CHK(regs.condition_flags, 8'h5a)
    load(8'h11, 16'h0000, 16'h1234, 8'h3c);
    issue(8'h94);
    `CHK(bus.kind, ctwd_pkg::CYC_FREE)
    `CHK(bus.rd, 1'b1)
    step;
    `CHK(bus.kind, ctwd_pkg::CYC_FETCH)
    step;
    `CHK(regs.stack_pointer, 16'hffff)
    `CHK(regs.condition_flags, 8'h3c)
  endtask : t_xfer

  // Wait opcode: clear mask, halt silently, wake on irq
  task t_wait;
    issue(8'h8f);
    `CHK(bus.kind, ctwd_pkg::CYC_FREE)
    step;
    `CHK(bus.kind, ctwd_pkg::CYC_FETCH)
    step;
    `CHK(int_mask, 1'b0)
    `CHK(halted, 1'b1)
    push_req = 1'b1;
    repeat (5) begin
      step;
      `CHK({bus.rd, bus.wr}, 2'b00)
    end
    push_req = 1'b0;
    irq = 1'b1;
    step;
    irq = 1'b0;
    for (int i = 0; i < 4 && halted === 1'b1; i++) step;
    `CHK(halted, 1'b0)
  endtask : t_wait

  // Address forms and bit selector
  task t_modes;
    ctwd_pkg::ctwd_mode_e m [8];
    logic [15:0]          o [8];
    logic [15:0]          e [8];
    m = '{ctwd_pkg::AM_DIRECT, ctwd_pkg::AM_IX_OFF8, ctwd_pkg::AM_IX_OFF16,
      ctwd_pkg::AM_IX_POSTINC, ctwd_pkg::AM_IX_OFF8_POSTINC,
      ctwd_pkg::AM_SP_OFF8, ctwd_pkg::AM_SP_OFF16, ctwd_pkg::AM_REL};
    o = '{16'h12ab, 16'h00ff, 16'h8001, 16'h0055, 16'h0010, 16'h0080,
      16'h1000, 16'h0080};
    e = '{16'h00ab, 16'h10ff, 16'h9001, 16'h1000, 16'h1010, 16'h0280,
      16'h1200, 16'h2f80};
    load(8'h00, 16'h1000, 16'h0200, 8'h00);
    am_pc_next = 16'h3000;
    for (int i = 0; i < 8; i++) begin
      am_mode = m[i];
      am_operand = o[i];
      step;
      step;
      `CHK(am_addr, e[i])
    end
    am_operand = 16'h007f;
    step;
    step;
    `CHK(am_addr, 16'h307f)
    for (int b = 0; b < 8; b++) begin
      am_bitnum = b[2:0];
      #1;
      `CHK(am_bitmask, 8'h01 << b)
    end
  endtask : t_modes

  // Push, pop, vector, post-increment read and a write
  task t_traffic;
    load(8'h00, 16'h2000, 16'h00ff, 8'h00);
    wr_data = 8'ha5;
    push_req = 1'b1;
    step;
    push_req = 1'b0;
    wait_bus;
    `CHK({bus.kind, bus.wr, bus.addr, bus.wdata}, {ctwd_pkg::CYC_PUSH, 1'b1, 16'h00ff, 8'ha5})
    step;
    step;
    `CHK(regs.stack_pointer, 16'h00fe)
    `CHK(ctwd_mem_model_i.mem[16'h00ff], 8'ha5)
    pop_req = 1'b1;
    step;
    pop_req = 1'b0;
    wait_bus;
    `CHK({bus.kind, bus.rd, bus.addr}, {ctwd_pkg::CYC_POP, 1'b1, 16'h00ff})
    step;
    vec_slot = 8'hfe;
    vec_req = 1'b1;
    step;
    vec_req = 1'b0;
    wait_bus;
    `CHK({bus.kind, bus.addr}, {ctwd_pkg::CYC_VECTOR, 16'hfffe})
    step;
    `CHK({bus.kind, bus.addr}, {ctwd_pkg::CYC_VECTOR, 16'hffff})
    step;
    am_mode = ctwd_pkg::AM_IX_POSTINC;
    step;
    rd_req = 1'b1;
    step;
    rd_req = 1'b0;
    wait_bus;
    `CHK({bus.kind, bus.rd, bus.addr}, {ctwd_pkg::CYC_READ, 1'b1, 16'h2000})
    step;
    step;
    `CHK(regs.index, 16'h2001)
    am_mode = ctwd_pkg::AM_DIRECT;
    am_operand = 16'h0040;
    wr_data = 8'h3c;
    step;
    wr_req = 1'b1;
    step;
    wr_req = 1'b0;
    wait_bus;
    `CHK({bus.kind, bus.wr, bus.addr}, {ctwd_pkg::CYC_WRITE, 1'b1, 16'h0040})
  endtask : t_traffic

  // Reset, then every scenario in turn
  initial begin
    {resetn, op_valid, push_req, pop_req, vec_req} = 5'h00;
    {rd_req, wr_req, irq, regs_load} = 4'h0;
    {op_code, vec_slot, wr_data, am_bitnum} = 27'h0;
    {am_operand, am_pc_next, regs_in} = 80'h0;
    am_mode = ctwd_pkg::AM_DIRECT;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    `CHK({regs, bus.kind, int_mask, op_ready}, {48'h0, ctwd_pkg::CYC_IDLE, 2'b11})
    t_xfer;
    t_wait;
    t_modes;
    t_traffic;
    results();
  end
endmodule : cpu_transfer_wait_decode_tb_top
